/* hdl/rdpc_checker.sv */
`timescale 1ns/10ps
// What this block does
// - a failed read parity check drives parity_fail_out_n low and pulses the core fault.
// - correct parity never fails and wrong parity always fails, regardless of history.
// - reads of 32, 16 and 8 bits are checked, lanes chosen from this access width only.
// - a 16-bit read ignores lanes D31:16 even after a 32-bit read.
// - an 8-bit read ignores lanes D15:8 even after a 16-bit read.
// - a wider read after a narrower one checks all its upper lanes and flags errors.
// - failures are reported only while checking is enabled.
module rdpc_checker
    import rdpc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic read_valid,
    input wire logic [1:0] read_width,
    input wire logic [RDPC_DATA_W-1:0] read_data,
    input wire logic [RDPC_LANES-1:0] read_parity,
    input wire logic check_enable,
    input wire logic odd_mode,
    output logic parity_fail_out_n,
    output logic parity_fault
);

    // decoded access width, one flag per code
    logic width_is_8;
    logic width_is_16;
    logic width_is_32;
    logic width_is_none;

    // lanes that this access defines
    logic [RDPC_LANES-1:0] lane_mask;
    logic [RDPC_LANES-1:0] lane_defined;

    // result of the lane checker for this beat
    logic fail_now;

    // qualifiers of the beat
    logic beat_taken;
    logic check_on;
    logic report_d;

    // output registers and their next values
    logic pin_d;
    logic pin_q;
    logic fault_d;
    logic fault_q;

    // width decode; code 3 carries no defined lanes
    always_comb begin
        width_is_8 = 1'b0;
        width_is_16 = 1'b0;
        width_is_32 = 1'b0;
        width_is_none = 1'b0;
        unique case (read_width)
            RDPC_W8: begin
                width_is_8 = 1'b1;
            end
            RDPC_W16: begin
                width_is_16 = 1'b1;
            end
            RDPC_W32: begin
                width_is_32 = 1'b1;
            end
            default: begin
                width_is_none = 1'b1;
            end
        endcase
    end

    // mask is a pure function of this access; no state kept across reads
    // so a prior wide or narrow read can never leak in
    always_comb begin
        lane_mask = RDPC_MASK_NONE;
        if (width_is_8) begin
            lane_mask = RDPC_MASK8;
        end
        if (width_is_16) begin
            lane_mask = RDPC_MASK16;
        end
        if (width_is_32) begin
            lane_mask = RDPC_MASK32;
        end
        if (width_is_none) begin
            lane_mask = RDPC_MASK_NONE;
        end
    end

    // per-lane enable, one bit per byte lane
    genvar g;
    generate
        for (g = 0; g < RDPC_LANES; g++) begin : g_lane_def
            assign lane_defined[g] = lane_mask[g];
        end
    endgenerate

    rdpc_lane_check u_lanes (
        .data(read_data),
        .parity(read_parity),
        .lane_en(lane_defined),
        .odd_mode(odd_mode),
        .lane_fail_any(fail_now)
    );

    // a beat counts only when presented on an enabled edge
    always_comb begin
        beat_taken = 1'b0;
        if (read_valid) begin
            beat_taken = 1'b1;
        end
    end

    // checking off masks every report, whatever the data
    always_comb begin
        check_on = 1'b0;
        if (check_enable) begin
            check_on = 1'b1;
        end
    end

    // one failure per read beat, never carried to the next
    always_comb begin
        report_d = 1'b0;
        if (beat_taken && check_on) begin
            report_d = fail_now;
        end
    end

    // pin is active low; idle high
    always_comb begin
        pin_d = 1'b1;
        if (report_d) begin
            pin_d = 1'b0;
        end
    end

    // fault pulse to the core in the same cycle as the pin
    always_comb begin
        fault_d = 1'b0;
        if (report_d) begin
            fault_d = 1'b1;
        end
    end

    // outputs frozen while clk_en is low; a stalled report stays visible
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_q <= 1'b1;
        end else if (clk_en) begin
            pin_q <= pin_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else if (clk_en) begin
            fault_q <= fault_d;
        end
    end

    // both outputs come straight from their flops
    assign parity_fail_out_n = pin_q;

    assign parity_fault = fault_q;

endmodule

/* hdl/rdpc_pkg.sv */
package rdpc_pkg;
    localparam int RDPC_DATA_W = 32;
    localparam int RDPC_LANES = 4;
    localparam int RDPC_LANE_W = 8;
    // access width codes on read_width
    localparam logic [1:0] RDPC_W8 = 2'h0;
    localparam logic [1:0] RDPC_W16 = 2'h1;
    localparam logic [1:0] RDPC_W32 = 2'h2;
    localparam logic [3:0] RDPC_MASK8 = 4'h1;
    localparam logic [3:0] RDPC_MASK16 = 4'h3;
    localparam logic [3:0] RDPC_MASK32 = 4'hf;
    localparam logic [3:0] RDPC_MASK_NONE = 4'h0;
    // parity sense: 1 means odd parity over data plus parity bit
    localparam logic RDPC_ODD_DEFAULT = 1'b1;
endpackage

/* hdl/rdpc_lane_check.sv */
`timescale 1ns/10ps
module rdpc_lane_check
    import rdpc_pkg::*;
(
    input wire logic [RDPC_DATA_W-1:0] data,
    input wire logic [RDPC_LANES-1:0] parity,
    input wire logic [RDPC_LANES-1:0] lane_en,
    input wire logic odd_mode,
    output logic lane_fail_any
);
    logic [RDPC_LANES-1:0] lane_bad;
    genvar g;
    generate
        for (g = 0; g < RDPC_LANES; g++) begin : g_lane
            // each lane checked against its own parity bit, masked by width
            assign lane_bad[g] = lane_en[g] &
                ((^data[g*RDPC_LANE_W +: RDPC_LANE_W]) ^ parity[g] ^ odd_mode);
        end
    endgenerate
    assign lane_fail_any = |lane_bad;
endmodule

/* bench/rdpc_mem.sv */
`timescale 1ns/10ps
module rdpc_mem (input wire logic odd_mode, input wire logic [3:0] bad,
    input wire logic [31:0] rnd, output logic [31:0] read_data, output logic [3:0] read_parity);
    // undefined lanes carry random data, so stale values never leak into the check
    assign read_data = rnd;
    for (genvar i = 0; i < 4; i++) assign read_parity[i] = ^rnd[8*i+:8] ^ odd_mode ^ bad[i];
endmodule

/* bench/rdpc_chk_assertions.sv */
`timescale 1ns/10ps
module rdpc_chk (input wire logic clk, sys_rst, clk_en, read_valid, check_enable,
    input wire logic [1:0] read_width, input wire logic parity_fail_out_n, parity_fault,
    input wire logic [31:0] read_data, input wire logic [3:0] read_parity,
    input wire logic odd_mode);
    logic [3:0] lane_bad;
    logic bad16, bad32;
    for (genvar i = 0; i < 4; i++) assign lane_bad[i] = ^read_data[8*i+:8] ^ read_parity[i] ^ odd_mode;
    assign bad16 = |lane_bad[1:0];
    assign bad32 = |lane_bad;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_w8;
        clk_en && read_valid && check_enable && read_width == 2'h0 |=> parity_fault == $past(lane_bad[0]);
    endproperty
    a_w8: assert property (p_w8) else $error("8-bit read result wrong");
    property p_w16;
        clk_en && read_valid && check_enable && read_width == 2'h1 |=> parity_fault == $past(bad16);
    endproperty
    a_w16: assert property (p_w16) else $error("16-bit read result wrong");
    property p_w32;
        clk_en && read_valid && check_enable && read_width == 2'h2 |=> parity_fault == $past(bad32);
    endproperty
    a_w32: assert property (p_w32) else $error("32-bit read result wrong");
    property p_off; clk_en && !check_enable |=> !parity_fault; endproperty
    a_off: assert property (p_off) else $error("fault while off");
    property p_idle; clk_en && (!read_valid || read_width == 2'h3) |=> !parity_fault; endproperty
    a_idle: assert property (p_idle) else $error("fault without read");
    property p_pair; parity_fault == !parity_fail_out_n; endproperty
    a_pair: assert property (p_pair) else $error("pin and fault differ");
    cover property (parity_fault && read_width == 2'h0);
    cover property (parity_fault && read_width == 2'h1);
    cover property (parity_fault && read_width == 2'h2);
endmodule
bind rdpc_checker rdpc_chk u_chk (.*);

/* bench/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 0, sys_rst = 1, clk_en = 0, read_valid = 0, check_enable = 0, odd_mode = 0;
    logic e, parity_fault, parity_fail_out_n;
    logic [1:0] read_width = 0;
    logic [3:0] bad = 0, read_parity;
    logic [31:0] rnd = 0, read_data;
    logic q[$];
    int failures = 0, n_tests = 0, seed = 32'h8d31;
    rdpc_checker u_dut (.*);
    rdpc_mem u_mem (.*);
    initial forever #20 clk = ~clk;
    task chk(input logic s, x);
        n_tests++;
        if (s !== x) failures++;
        if (s !== x) $display("Error %0t saw %b want %b", $time, s, x);
    endtask
    task finish_test;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        if (sys_rst) e = 0;
        if (sys_rst) q.delete();
        else begin
            if (q.size() > 0) chk(!parity_fail_out_n, q[0]);
            if (q.size() > 0) chk(parity_fault, q.pop_front());
            // frozen outputs keep the last result, so the model keeps it too
            if (clk_en) e = 0;
            for (int n = 0; clk_en && n < (read_width == 3 ? 0 : 1 << read_width); n++)
                e |= read_valid && check_enable && (^read_data[8*n+:8] ^ read_parity[n]) != odd_mode;
            q.push_back(e);
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        repeat (3000) begin
            sys_rst <= ($random(seed) & 255) == 0;
            {rnd, read_width, odd_mode, read_valid, clk_en, check_enable, bad} <= 42'({$random(seed), $random(seed)});
            @(posedge clk);
        end
        finish_test;
    end
    initial begin
        #150000;
        failures++;
        finish_test;
    end
endmodule
